/* File: hw/smc_top.sv */
/*
  Serial command front end of a byte-wide nonvolatile memory: serial
  shifter on the serial clock, command decoder, write latch, status
  register and write protection on the system clock.
  Assumes the array sits outside and takes one write strobe per byte,
  and that select stays high for at least four system clocks between frames.
*/
`timescale 1ns/1ps
`default_nettype none
`include "smc_params.svh"

module smc_top import smc_pkg::*; #(
  parameter int ADDR_W = `SMC_ADDR_W
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_sclk,
  input wire logic i_cs_b,
  input wire logic i_si,
  input wire logic i_hold_b,
  input wire logic i_wp_b,
  input wire logic [2:0] i_nv_guard,
  output logic o_so,
  output logic o_so_oe_b,
  output logic [2:0] o_nv_guard,
  output logic o_mem_wr,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  output logic [7:0] o_status,
  output logic [3:0] o_cmd,
  output logic o_cmd_done,
  output logic o_frame_mode3
);
  // ==========================================================
  // Elaboration check: guard ranges assume a 15-bit array
  if (ADDR_W != `SMC_ADDR_W) begin : g_bad_addr
    $error("smc_top supports only the documented address width");
  end

  // ==========================================================
  // Reset release
  logic [1:0] rst_ff_r; // Release shift
  logic rst_n;          // Synchronised reset, active low
  logic frame_clr;      // Clears serial logic between frames

  // Assert at once, release after two edges
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_ff_r <= 2'b00;
    end else begin
      rst_ff_r <= {rst_ff_r[0], 1'b1};
    end
  end
  assign rst_n = rst_ff_r[1];
  // Select high holds the shift and output flops in reset; the byte hand-off and mode capture are kept
  assign frame_clr = i_cs_b | ~rst_n;

  // ==========================================================
  // Serial clock domain
  logic [2:0] bit_cnt_r;   // Bit within current byte
  logic [6:0] sh_r;        // Received bits so far
  logic first_r;           // Still inside the command byte
  logic tx_en_r;           // Status byte is to be returned
  logic [7:0] tx_word_r;   // Byte being returned
  logic [3:0] out_cnt_r;   // Bits already driven
  logic so_r;              // Output data flop
  logic drv_r;             // Output is being driven
  logic [7:0] rx_byte_r;   // Last complete byte
  logic rx_tgl_r;          // Flips once per complete byte
  logic mode3_r;           // Clock idle level at select fall
  logic [7:0] rx_full;     // Byte including the current bit
  logic [7:0] status_w;    // Status word, system domain

  assign rx_full = {sh_r, i_si};

  // Mode capture; both modes shift alike, only the idle level differs
  always_ff @(negedge i_cs_b or negedge rst_n) begin
    if (!rst_n) begin
      mode3_r <= 1'b0;
    end else begin
      mode3_r <= i_sclk;
    end
  end

  // Input shift on rising edges, frozen by hold
  always_ff @(posedge i_sclk or posedge frame_clr) begin
    if (frame_clr) begin
      bit_cnt_r <= 3'h0;
      sh_r <= 7'h00;
      first_r <= 1'b1;
      tx_en_r <= 1'b0;
      tx_word_r <= 8'h00;
    end else if (i_hold_b) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      sh_r <= rx_full[6:0];
      if (bit_cnt_r == 3'h7) begin
        first_r <= 1'b0;
        // Status word is stable while select is low
        if (first_r && rx_full == `SMC_OP_STATUS_FETCH) begin
          tx_en_r <= 1'b1;
          tx_word_r <= status_w;
        end
      end
    end
  end

  // Byte hand-off; survives select so the toggle stays in step
  always_ff @(posedge i_sclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_byte_r <= 8'h00;
      rx_tgl_r <= 1'b0;
    end else if (i_hold_b && !frame_clr && bit_cnt_r == 3'h7) begin
      rx_byte_r <= rx_full;
      rx_tgl_r <= ~rx_tgl_r;
    end
  end

  // Output shift on falling edges, one byte only
  always_ff @(negedge i_sclk or posedge frame_clr) begin
    if (frame_clr) begin
      out_cnt_r <= 4'h0;
      so_r <= 1'b0;
      drv_r <= 1'b0;
    end else if (tx_en_r && i_hold_b) begin
      if (out_cnt_r != 4'h8) begin
        so_r <= tx_word_r[~out_cnt_r[2:0]];
        out_cnt_r <= out_cnt_r + 4'h1;
        drv_r <= 1'b1;
      end else begin
        drv_r <= 1'b0;
      end
    end
  end

  assign o_so = so_r;
  // Hold and select float the pin at once, whatever the flops say
  assign o_so_oe_b = ~(drv_r & i_hold_b & ~i_cs_b);

  // ==========================================================
  // Crossing into the system domain
  logic [3:0] sync_q; // Select and pin inverted, so a cleared stage reads idle
  logic cs_s;         // Synchronised select
  logic wp_s;         // Synchronised protect pin
  logic tgl_s;        // Synchronised byte toggle
  logic tgl_d_r;      // Previous toggle
  logic cs_d_r;       // Select, one more stage
  logic cs_e_r;       // Select, delayed end
  logic rx_evt;       // A byte has arrived
  logic end_evt;      // Frame has ended

  smc_sync #(.W(4)) u_sync (
    .i_clk(i_mclk),
    .i_rst_b(rst_n),
    .i_d({~i_cs_b, ~i_wp_b, rx_tgl_r, mode3_r}),
    .o_q(sync_q)
  );
  assign cs_s = ~sync_q[3];
  assign wp_s = ~sync_q[2];
  assign tgl_s = sync_q[1];
  assign o_frame_mode3 = sync_q[0];

  // Edge stages; the end waits one cycle so a late last byte lands first
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_d_r <= 1'b0;
      cs_d_r <= 1'b1;
      cs_e_r <= 1'b1;
    end else begin
      tgl_d_r <= tgl_s;
      cs_d_r <= cs_s;
      cs_e_r <= cs_d_r;
    end
  end
  assign rx_evt = tgl_s ^ tgl_d_r;
  assign end_evt = cs_d_r & ~cs_e_r;

  // ==========================================================
  // Command decoder
  smc_state_type state_r;       // Byte position
  smc_cmd_type cmd_r;           // Command of this frame
  smc_cmd_type last_cmd_r;      // Last finished command
  logic [ADDR_W-1:0] addr_r;    // Running address
  logic [7:0] pend_r;           // Status byte waiting for frame end
  logic pend_v_r;               // Status byte present
  logic mem_wr_r;               // Array write strobe
  logic [ADDR_W-1:0] mem_addr_r;
  logic [7:0] mem_data_r;
  logic cmd_done_r;
  smc_cmd_type op_cmd;          // Decode of the arriving byte
  smc_state_type op_next;       // State after the command byte
  smc_guard_if g_if ();

  assign op_cmd = smc_decode(rx_byte_r);
  assign op_next = (op_cmd == SMC_CMD_STORE || op_cmd == SMC_CMD_FETCH ||
                    op_cmd == SMC_CMD_QUICK_FETCH) ? SMC_ST_ADDR_HI :
                   (op_cmd == SMC_CMD_STATUS_LOAD) ? SMC_ST_STATUS : SMC_ST_DONE;

  // Frame sequencing; later bytes never touch the command
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= SMC_ST_OPCODE;
      cmd_r <= SMC_CMD_NONE;
      last_cmd_r <= SMC_CMD_NONE;
      addr_r <= '0;
      pend_r <= 8'h00;
      pend_v_r <= 1'b0;
      mem_wr_r <= 1'b0;
      mem_addr_r <= '0;
      mem_data_r <= 8'h00;
      cmd_done_r <= 1'b0;
    end else begin
      mem_wr_r <= 1'b0;
      cmd_done_r <= end_evt;
      if (end_evt) begin
        // Select rise ends every frame, finished or not
        state_r <= SMC_ST_OPCODE;
        cmd_r <= SMC_CMD_NONE;
        last_cmd_r <= cmd_r;
        pend_v_r <= 1'b0;
      end else if (rx_evt) begin
        unique case (state_r)
          SMC_ST_OPCODE: begin
            cmd_r <= op_cmd;
            state_r <= op_next;
          end
          SMC_ST_ADDR_HI: begin
            addr_r[14:8] <= rx_byte_r[6:0];
            state_r <= SMC_ST_ADDR_LO;
          end
          SMC_ST_ADDR_LO: begin
            addr_r[7:0] <= rx_byte_r;
            // Fetch commands stop after the address; no read data phase is built
            state_r <= (cmd_r == SMC_CMD_STORE) ? SMC_ST_DATA : SMC_ST_DONE;
          end
          SMC_ST_DATA: begin
            // Refused bytes are swallowed without a strobe
            if (g_if.mem_ok) begin
              mem_wr_r <= 1'b1;
              mem_addr_r <= addr_r;
              mem_data_r <= rx_byte_r;
            end
            addr_r <= addr_r + 15'h0001;
          end
          SMC_ST_STATUS: begin
            pend_r <= rx_byte_r;
            pend_v_r <= 1'b1;
            state_r <= SMC_ST_DONE;
          end
          SMC_ST_DONE: begin
            state_r <= SMC_ST_DONE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Write latch and status register
  logic latch_r;         // Write latch
  logic latch_nxt;
  logic [2:0] guard_r;   // Pin guard, block guard hi, lo
  logic [2:0] guard_nxt;
  logic loaded_r;        // Kept guard bits fetched
  logic load_ok;         // Status load granted at frame end
  logic wr_end;          // A write command has finished

  assign wr_end = end_evt && (cmd_r == SMC_CMD_STORE || cmd_r == SMC_CMD_STATUS_LOAD);
  assign latch_nxt = (end_evt && cmd_r == SMC_CMD_LATCH_SET) ? 1'b1 :
                     (end_evt && cmd_r == SMC_CMD_LATCH_CLEAR) ? 1'b0 :
                     wr_end ? 1'b0 : latch_r;
  assign load_ok = end_evt && cmd_r == SMC_CMD_STATUS_LOAD && pend_v_r && g_if.status_ok;
  // The latch flag of the loaded byte is dropped on purpose
  assign guard_nxt = !loaded_r ? i_nv_guard :
                     load_ok ? {pend_r[`SMC_ST_PIN_GUARD], pend_r[`SMC_ST_GUARD_HI],
                                pend_r[`SMC_ST_GUARD_LO]} : guard_r;

  // Latch is volatile; guard bits come back from the kept copy
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= 1'b0;
      guard_r <= `SMC_GUARD_RESET;
      loaded_r <= 1'b0;
    end else begin
      latch_r <= latch_nxt;
      guard_r <= guard_nxt;
      loaded_r <= 1'b1;
    end
  end

  assign g_if.latch = latch_r;
  assign g_if.pin_guard = guard_r[2];
  assign g_if.wp_b = wp_s;
  assign g_if.guard = guard_r[1:0];
  assign g_if.addr = addr_r;

  smc_guard u_guard (
    .g(g_if)
  );

  // Fixed zeros in bits 6..4 and 0
  assign status_w = {guard_r[2], 3'b000, guard_r[1:0], latch_r, 1'b0};

  assign o_status = status_w;
  assign o_nv_guard = guard_r;
  assign o_mem_wr = mem_wr_r;
  assign o_mem_addr = mem_addr_r;
  assign o_mem_wdata = mem_data_r;
  assign o_cmd = last_cmd_r;
  assign o_cmd_done = cmd_done_r;

  // ==========================================================
  // Checks
  sequence s_load_granted;
    load_ok;
  endsequence
  sequence s_load_blocked;
    end_evt && cmd_r == SMC_CMD_STATUS_LOAD && guard_r[2] && !wp_s;
  endsequence

  property p_latch_set;
    @(posedge i_mclk) disable iff (!rst_n)
      end_evt && cmd_r == SMC_CMD_LATCH_SET |=> latch_r ##1 status_w[1];
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch not set");

  property p_latch_clear;
    @(posedge i_mclk) disable iff (!rst_n)
      end_evt && (cmd_r == SMC_CMD_LATCH_CLEAR || cmd_r == SMC_CMD_STORE) |=> !latch_r;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared");

  property p_mem_guard;
    @(posedge i_mclk) disable iff (!rst_n)
      o_mem_wr |-> $past(latch_r) && $past(guard_r[1:0]) != 2'b11;
  endproperty
  a_mem_guard: assert property (p_mem_guard) else $error("guarded write passed");

  property p_load_applies;
    @(posedge i_mclk) disable iff (!rst_n)
      s_load_granted |=> guard_r == {$past(pend_r[7]), $past(pend_r[3]), $past(pend_r[2])} && !latch_r;
  endproperty
  a_load_applies: assert property (p_load_applies) else $error("status load lost");

  property p_load_blocked;
    @(posedge i_mclk) disable iff (!rst_n)
      s_load_blocked |=> $stable(guard_r);
  endproperty
  a_load_blocked: assert property (p_load_blocked) else $error("pin did not block load");

  property p_layout;
    @(posedge i_mclk) disable iff (!rst_n)
      (o_status & `SMC_ST_ZERO_MASK) == 8'h00 && o_status[1] == latch_r;
  endproperty
  a_layout: assert property (p_layout) else $error("status layout wrong");

  property p_one_cmd;
    @(posedge i_mclk) disable iff (!rst_n)
      rx_evt && !end_evt && state_r != SMC_ST_OPCODE |=> cmd_r == $past(cmd_r);
  endproperty
  a_one_cmd: assert property (p_one_cmd) else $error("second command taken");

  property p_first_byte;
    @(posedge i_mclk) disable iff (!rst_n)
      rx_evt && !end_evt && state_r == SMC_ST_OPCODE |=> cmd_r == smc_decode($past(rx_byte_r));
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("command byte missed");

  property p_quiet;
    @(posedge i_mclk) disable iff (!rst_n)
      (i_cs_b || !i_hold_b) |-> o_so_oe_b;
  endproperty
  a_quiet: assert property (p_quiet) else $error("output driven while idle");

  property p_one_byte;
    @(negedge i_sclk) disable iff (frame_clr)
      tx_en_r && i_hold_b && out_cnt_r == 4'h8 |=> !drv_r;
  endproperty
  a_one_byte: assert property (p_one_byte) else $error("status byte overrun");
endmodule

`default_nettype wire

/* File: hw/smc_params.svh */
/*
  Constants of the serial command front end: op-codes, status field
  positions, zero mask, guard boundaries and address width.
  Assumes it is included by bare name; definitions only.
*/
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH

// ==========================================================
// Op-codes, first byte of every frame
`define SMC_OP_LATCH_SET 8'h06
`define SMC_OP_LATCH_CLEAR 8'h04
`define SMC_OP_STATUS_FETCH 8'h05
`define SMC_OP_STATUS_LOAD 8'h01
`define SMC_OP_FETCH 8'h03
`define SMC_OP_QUICK_FETCH 8'h0b
`define SMC_OP_STORE 8'h02
`define SMC_OP_SLEEP 8'hb9
`define SMC_OP_IDENTITY 8'h9f
`define SMC_OP_SERIAL 8'hc3

// ==========================================================
// Status register layout
`define SMC_ST_PIN_GUARD 7
`define SMC_ST_GUARD_HI 3
`define SMC_ST_GUARD_LO 2
`define SMC_ST_LATCH 1
`define SMC_ST_ZERO_MASK 8'h71

// ==========================================================
// Array geometry and guarded ranges
`define SMC_ADDR_W 15
`define SMC_QUARTER_BASE 15'h6000
`define SMC_HALF_BASE 15'h4000
`define SMC_GUARD_RESET 3'h0

`endif

/* File: hw/smc_pkg.sv */
/*
  Types of the serial command front end: command codes, decoder
  states and the op-code decode function.
  Assumes smc_params.svh is on the include path.
*/
`default_nettype none
`include "smc_params.svh"

package smc_pkg;
  // ==========================================================
  // Decoded command of a frame
  typedef enum logic [3:0] {
    SMC_CMD_NONE = 4'h0, SMC_CMD_LATCH_SET = 4'h1, SMC_CMD_LATCH_CLEAR = 4'h2,
    SMC_CMD_STATUS_FETCH = 4'h3, SMC_CMD_STATUS_LOAD = 4'h4, SMC_CMD_FETCH = 4'h5,
    SMC_CMD_QUICK_FETCH = 4'h6, SMC_CMD_STORE = 4'h7, SMC_CMD_SLEEP = 4'h8,
    SMC_CMD_IDENTITY = 4'h9, SMC_CMD_SERIAL = 4'ha, SMC_CMD_UNKNOWN = 4'hb
  } smc_cmd_type;

  // Byte position within a frame
  typedef enum logic [2:0] {
    SMC_ST_OPCODE = 3'b000, SMC_ST_ADDR_HI = 3'b001, SMC_ST_ADDR_LO = 3'b010,
    SMC_ST_DATA = 3'b011, SMC_ST_STATUS = 3'b100, SMC_ST_DONE = 3'b101
  } smc_state_type;

  // Op-code to command
  function automatic smc_cmd_type smc_decode(input logic [7:0] op);
    smc_cmd_type c;
    c = SMC_CMD_UNKNOWN;
    case (op)
      `SMC_OP_LATCH_SET: c = SMC_CMD_LATCH_SET;
      `SMC_OP_LATCH_CLEAR: c = SMC_CMD_LATCH_CLEAR;
      `SMC_OP_STATUS_FETCH: c = SMC_CMD_STATUS_FETCH;
      `SMC_OP_STATUS_LOAD: c = SMC_CMD_STATUS_LOAD;
      `SMC_OP_FETCH: c = SMC_CMD_FETCH;
      `SMC_OP_QUICK_FETCH: c = SMC_CMD_QUICK_FETCH;
      `SMC_OP_STORE: c = SMC_CMD_STORE;
      `SMC_OP_SLEEP: c = SMC_CMD_SLEEP;
      `SMC_OP_IDENTITY: c = SMC_CMD_IDENTITY;
      `SMC_OP_SERIAL: c = SMC_CMD_SERIAL;
      default: c = SMC_CMD_UNKNOWN;
    endcase
    return c;
  endfunction
endpackage

`default_nettype wire

/* File: hw/smc_guard_if.sv */
/*
  Carrier between the decoder and the protection check.
  Assumes both ends sit in the system clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

interface smc_guard_if;
  logic latch;        // Write latch state
  logic pin_guard;    // Pin guard enable bit
  logic wp_b;         // Synchronised protect pin
  logic [1:0] guard;  // Block guard bits
  logic [14:0] addr;  // Target address
  logic mem_ok;       // Array write allowed
  logic status_ok;    // Status write allowed
  modport ctl(output latch, pin_guard, wp_b, guard, addr, input mem_ok, status_ok);
  modport chk(input latch, pin_guard, wp_b, guard, addr, output mem_ok, status_ok);
endinterface

`default_nettype wire

/* File: hw/smc_sync.sv */
/*
  Two flip-flop synchroniser for a bundle of independent levels.
  Assumes each bit is a level that no other bit depends on.
*/
`timescale 1ns/1ps
`default_nettype none

module smc_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  // ==========================================================
  // Width check
  if (W < 1) begin : g_bad_w
    $error("smc_sync width must be at least one");
  end

  logic [W-1:0] meta_r; // First stage, read only by the second
  logic [W-1:0] sync_r; // Second stage

  // Both stages clear together
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_d;
      sync_r <= meta_r;
    end
  end

  assign o_q = sync_r;
endmodule

`default_nettype wire

/* File: hw/smc_guard.sv */
/*
  Write protection check: block guard ranges, write latch and pin guard.
  Assumes all inputs come from the system clock domain; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
`include "smc_params.svh"

module smc_guard import smc_pkg::*; (
  smc_guard_if.chk g
);
  // ==========================================================
  // Range decode
  logic in_quarter; // Upper quarter of the array
  logic in_half;    // Upper half of the array
  logic guarded;    // Address lies in the guarded range
  assign in_quarter = (g.addr >= `SMC_QUARTER_BASE);
  assign in_half = (g.addr >= `SMC_HALF_BASE);
  // Value 11 covers every address, so no compare is needed there
  assign guarded = (g.guard == 2'b01) ? in_quarter :
                   (g.guard == 2'b10) ? in_half :
                   (g.guard == 2'b11);

  // ==========================================================
  // Verdicts; the pin never reaches the array path
  assign g.mem_ok = g.latch & ~guarded;
  // Pin only counts while its enable bit is set
  assign g.status_ok = g.latch & ~(g.pin_guard & ~g.wp_b);
endmodule

`default_nettype wire

/* File: sim/smc_host_model.sv */
/*
  Serial master model that drives frames into the command front end.
  Assumes a 15 ns link clock that stands still between frames.
*/
`timescale 1ns/1ps
`default_nettype none

module smc_host_model (
  input wire logic i_so,
  input wire logic i_so_oe_b,
  output logic o_sclk,
  output logic o_cs_b,
  output logic o_si,
  output logic o_hold_b
);
  logic [7:0] rx; // Last byte read back
  logic oe_seen; // Output was driven in frame

  // ==========================================
  // Idle bus: deselected until the bench starts
  initial begin
    o_sclk = 1'b0;
    o_cs_b = 1'b1;
    o_si = 1'b0;
    o_hold_b = 1'b1;
  end

  // ==========================================
  // One frame of n bytes, MSB first, optional hold pause
  task automatic run(input logic m3, input int n, input logic [39:0] tx, input logic hp);
    #1.3 o_sclk = m3;
    #7.5 o_cs_b = 1'b0;
    oe_seen = 1'b0;
    for (int i = 0; i < 8 * n; i++) begin
      #7.5 o_sclk = 1'b0;
      o_si = tx[39-i];
      if (hp && i == 3) begin
        // Hold moves only while the clock sits low, never on its edge
        #3 o_hold_b = 1'b0;
        #4.5 o_si = ~o_si;
        o_sclk = 1'b1;
        #7.5 o_sclk = 1'b0;
        #3 o_hold_b = 1'b1;
        o_si = tx[39-i];
      end
      #7.5 o_sclk = 1'b1;
      rx = {rx[6:0], i_so};
      oe_seen = oe_seen | (i_so_oe_b === 1'b0);
    end
    #7.5 o_sclk = m3;
    #7.5 o_cs_b = 1'b1;
    // Released line carries no defined level
    o_si = ~o_si;
  endtask
endmodule

`default_nettype wire

/* File: sim/tb_smc_top.sv */
/*
  Self-checking bench of the serial command front end.
  Assumes smc_host_model plays the serial master.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_smc_top import smc_pkg::*; ;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic wp_b = 1'b1;
  logic [2:0] nv_in = 3'h0; // Kept guard copy, loaded from nv_out before the second reset
  wire logic sclk, cs_b, si, hold_b, so, so_oe_b, mem_wr, cmd_done, mode3;
  wire logic [2:0] nv_out;
  wire logic [14:0] mem_addr;
  wire logic [7:0] mem_wdata, status;
  wire logic [3:0] cmd;
  int miscompares = 0;
  int checked = 0;
  int wr_n = 0; // Array write strobes seen
  int n;
  logic [15:0] wr_a, wr_d;
  logic [14:0] adr [3] = '{15'h3fff, 15'h4000, 15'h6000};
  logic [7:0] ops [10] = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h0b, 8'h02, 8'h9f, 8'hc3, 8'hb9};
  smc_cmd_type cmds [10] = '{SMC_CMD_LATCH_SET, SMC_CMD_LATCH_CLEAR, SMC_CMD_STATUS_FETCH,
    SMC_CMD_STATUS_LOAD, SMC_CMD_FETCH, SMC_CMD_QUICK_FETCH, SMC_CMD_STORE,
    SMC_CMD_IDENTITY, SMC_CMD_SERIAL, SMC_CMD_SLEEP};

  smc_top u_dut (.i_mclk(mclk), .i_rst_b(rst_b), .i_sclk(sclk), .i_cs_b(cs_b), .i_si(si),
    .i_hold_b(hold_b), .i_wp_b(wp_b), .i_nv_guard(nv_in), .o_so(so), .o_so_oe_b(so_oe_b),
    .o_nv_guard(nv_out), .o_mem_wr(mem_wr), .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata),
    .o_status(status), .o_cmd(cmd), .o_cmd_done(cmd_done), .o_frame_mode3(mode3));
  smc_host_model u_host (.i_so(so), .i_so_oe_b(so_oe_b), .o_sclk(sclk), .o_cs_b(cs_b),
    .o_si(si), .o_hold_b(hold_b));

  // ==========================================
  // Clock and array strobe monitor, sampled mid-cycle where the pulse has settled
  initial forever #4 mclk = ~mclk;
  always @(negedge mclk) begin
    if (mem_wr === 1'b1) begin
      wr_n++;
      wr_a = {1'b0, mem_addr};
      wr_d = {8'h0, mem_wdata};
    end
  end

  // ==========================================
  // Compare, verdict and frame helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Frame, then a bounded wait for the end-of-frame pulse
  task automatic frame(input logic m3, input int nb, input logic [39:0] tx, input logic hp,
    input smc_cmd_type ec);
    int k;
    u_host.run(m3, nb, tx, hp);
    k = 0;
    while (cmd_done !== 1'b1 && k < 40) begin
      @(negedge mclk);
      k++;
    end
    chk(16'(k < 40), 16'h1);
    @(negedge mclk);
    chk(cmd, ec);
    @(negedge mclk);
  endtask

  task automatic latch_on();
    frame(1'b0, 1, {8'h06, 32'h0}, 1'b0, SMC_CMD_LATCH_SET);
  endtask

  task automatic load(input logic [7:0] v);
    latch_on();
    frame(1'b1, 2, {8'h01, v, 24'h0}, 1'b0, SMC_CMD_STATUS_LOAD);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    repeat (8) @(negedge mclk);
    rst_b = 1'b1;
    repeat (8) @(negedge mclk);
    chk(status, 16'h0);
    chk(so_oe_b, 16'h1);
    n = wr_n;
    frame(1'b0, 4, {8'h02, 16'h0010, 8'h55, 8'h0}, 1'b0, SMC_CMD_STORE);
    chk(16'(wr_n), 16'(n));
    frame(1'b1, 1, {8'h06, 32'h0}, 1'b1, SMC_CMD_LATCH_SET);
    chk(mode3, 16'h1);
    chk(status, 16'h02);
    frame(1'b0, 2, {8'h05, 32'h0}, 1'b0, SMC_CMD_STATUS_FETCH);
    chk(mode3, 16'h0);
    chk(u_host.rx, 16'h02);
    chk(u_host.oe_seen, 16'h1);
    frame(1'b0, 1, {8'h04, 32'h0}, 1'b0, SMC_CMD_LATCH_CLEAR);
    chk(status, 16'h0);
    chk(u_host.oe_seen, 16'h0);
    load(8'hff);
    chk(status, 16'h8c);
    chk(nv_out, 16'h7);
    wp_b = 1'b0;
    load(8'h00);
    chk(status, 16'h8c);
    wp_b = 1'b1;
    load(8'h00);
    chk(status, 16'h0);
    wp_b = 1'b0;
    load(8'h04);
    chk(status, 16'h04);
    // Pin held low: it must not touch array writes
    for (int g = 0; g < 4; g++) begin
      load({4'h0, 2'(g), 2'b00});
      for (int j = 0; j < 3; j++) begin
        n = wr_n;
        latch_on();
        frame(1'b0, 4, {8'h02, 1'b0, adr[j], 8'ha0 + 8'(j), 8'h0}, 1'b0, SMC_CMD_STORE);
        chk(16'(wr_n - n), 16'(g == 0 || (g == 1 && j < 2) || (g == 2 && j < 1)));
        chk(status[1], 16'h0);
        if (wr_n != n) chk(wr_a, {1'b0, adr[j]});
        if (wr_n != n) chk(wr_d, 16'ha0 + 16'(j));
      end
    end
    // Two bytes across the top address wrap to zero
    load(8'h00);
    n = wr_n;
    latch_on();
    frame(1'b0, 5, {8'h02, 16'h7fff, 8'h11, 8'h22}, 1'b0, SMC_CMD_STORE);
    chk(16'(wr_n - n), 16'h2);
    chk(wr_a, 16'h0);
    chk(wr_d, 16'h22);
    wp_b = 1'b1;
    // A second op-code inside one frame is ignored
    frame(1'b0, 2, {8'h06, 8'h04, 24'h0}, 1'b0, SMC_CMD_LATCH_SET);
    chk(status[1], 16'h1);
    frame(1'b1, 1, {8'h00, 32'h0}, 1'b0, SMC_CMD_UNKNOWN);
    frame(1'b0, 0, 40'h0, 1'b0, SMC_CMD_NONE);
    for (int i = 0; i < 10; i++) frame(1'b0, 1, {ops[i], 32'h0}, 1'b0, cmds[i]);
    // Guard bits come back through the kept copy after reset; the latch does not
    load(8'h88);
    chk(status, 16'h88);
    nv_in = nv_out;
    rst_b = 1'b0;
    repeat (8) @(negedge mclk);
    rst_b = 1'b1;
    repeat (8) @(negedge mclk);
    chk(status, 16'h88);
    chk(so_oe_b, 16'h1);
    final_report();
  end

  // ==========================================
  // Watchdog, well beyond the expected run length
  initial begin
    #400000;
    miscompares++;
    final_report();
  end
endmodule

`default_nettype wire
